// ==== design/xbap_top.v ====
// Expansion bus: asynchronous peripheral master and synchronous host port slave.
// Assumes a plain register port on i_ref_clk; all pins asynchronous to it.
//
// Our own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`include "xbap_regs.vh"

module xbap_top (
  // Clock, reset, enable
  input  wire        i_ref_clk,
  input  wire        i_rst_n,
  input  wire        i_ce,
  // Register port
  input  wire [3:0]  i_reg_addr,
  input  wire [31:0] i_reg_wdata,
  input  wire        i_reg_wr,
  input  wire        i_reg_rd,
  output reg  [31:0] o_reg_rdata,
  // Boot straps
  input  wire        i_boot_dir_pol,
  input  wire        i_boot_last_pol,
  // Peripheral side pins
  output reg  [3:0]  o_space_chip_enable_n,
  output reg  [3:0]  o_byte_lane_pins,
  output reg         o_byte_lane_pins_oe,
  output reg         o_peripheral_output_enable_n,
  output reg         o_read_strobe_n,
  output reg         o_write_strobe_n,
  output reg         o_write_strobe_oe,
  // Shared ready line
  input  wire        i_bus_ready_line,
  output reg         o_bus_ready_line,
  output reg         o_bus_ready_line_oe,
  // Shared data lines
  input  wire [31:0] i_bus_data_lines,
  output reg  [31:0] o_bus_data_lines,
  output reg         o_bus_data_lines_oe,
  // Host port inputs
  input  wire        i_host_bus_clock,
  input  wire        i_host_port_select_n,
  input  wire        i_host_address_strobe_n,
  input  wire        i_host_control_select,
  input  wire        i_transfer_direction,
  input  wire        i_burst_last_flag,
  input  wire [3:0]  i_byte_lane_enables_n
);
  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_SETUP = 3'h1;
  localparam [2:0] ST_STRB  = 3'h2;
  localparam [2:0] ST_RDYW  = 3'h3;
  localparam [2:0] ST_HOLD  = 3'h4;
  localparam [2:0] ST_HOST  = 3'h5;
  localparam [2:0] ST_REL   = 3'h6;

  // ----------------------------------------
  // Synchronisers
  // ----------------------------------------
  wire [42:0] sync_in;
  wire [42:0] sync_q;
  assign sync_in = {i_host_bus_clock, i_host_port_select_n, i_host_address_strobe_n,
                    i_host_control_select, i_transfer_direction, i_burst_last_flag,
                    i_byte_lane_enables_n, i_bus_ready_line, i_bus_data_lines};
  xbap_sync2 #(.W(43)) u_sync (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_ce      (i_ce),
    .i_async   (sync_in),
    .o_sync    (sync_q)
  );
  wire        hclk_s = sync_q[42];
  wire        hsel_n = sync_q[41];
  wire        has_n  = sync_q[40];
  wire        hctl   = sync_q[39];
  wire        hdir   = sync_q[38];
  wire        hlast  = sync_q[37];
  wire [3:0]  hbe_n  = sync_q[36:33];
  wire        rdy_s  = sync_q[32];
  wire [31:0] dat_s  = sync_q[31:0];

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg  [23:0] ctl_r [0:3];
  reg  [7:0]  cmd_r;
  reg  [31:0] wdata_r;
  reg  [31:0] rdata_r;
  reg  [31:0] hdata_r;
  reg  [1:0]  cfg_r;
  reg         busy_r;
  reg         dir_pol_r;
  reg         last_pol_r;
  reg         strap_done_r;
  reg  [2:0]  st_r;
  reg  [3:0]  cnt_r;
  reg  [2:0]  tail_r;
  reg  [2:0]  rcnt_r;
  reg         use_rdy_r;
  reg         hclk_d_r;
  reg         host_rd_r;
  reg         host_last_r;
  reg  [1:0]  rcap_r;

  function [3:0] fld;
    input [23:0] ctl;
    input [4:0]  lsb;
    begin
      fld = ctl[lsb +: 4];
    end
  endfunction

  wire [23:0] cur_ctl = ctl_r[cmd_r[1:0]];
  wire        is_wr   = cmd_r[`XBAP_CMD_WR_BIT];
  wire [3:0]  c_set   = fld(cur_ctl, is_wr ? `XBAP_WS_LSB  : `XBAP_RS_LSB);
  wire [3:0]  c_stb   = fld(cur_ctl, is_wr ? `XBAP_WST_LSB : `XBAP_RST_LSB);
  wire [3:0]  c_hld   = fld(cur_ctl, is_wr ? `XBAP_WH_LSB  : `XBAP_RH_LSB);
  wire [4:0]  sum_ss  = {1'b0, c_set} + {1'b0, c_stb};
  wire        hclk_rise = hclk_s & ~hclk_d_r;
  wire        host_dir_wr = hdir ^ dir_pol_r;
  wire        host_is_last = hlast ^ last_pol_r;
  wire        go = i_reg_wr && (i_reg_addr == `XBAP_OFF_CMD) && i_reg_wdata[`XBAP_CMD_GO_BIT];

  // Host read words queue towards the pins; software may stall the source
  wire        hq_in_valid = i_reg_wr && (i_reg_addr == `XBAP_OFF_HOSTDATA);
  wire        hq_in_ready;
  wire        hq_out_valid;
  wire [31:0] hq_out_data;
  wire        hq_pop = (st_r == ST_HOST) && hclk_rise && !hsel_n && host_rd_r && hq_out_valid;
  xbap_buf2 #(.W(32)) u_buf (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_ce      (i_ce),
    .i_valid   (hq_in_valid),
    .o_ready   (hq_in_ready),
    .i_data    (i_reg_wdata),
    .o_valid   (hq_out_valid),
    .i_ready   (hq_pop),
    .o_data    (hq_out_data)
  );

  // ----------------------------------------
  // Register writes and strap capture
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_ctl
      always @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
          ctl_r[g] <= `XBAP_CTL_RESET;
        end else if (i_ce && i_reg_wr && (i_reg_addr == g)) begin
          ctl_r[g] <= i_reg_wdata[23:0];
        end
      end
    end
  endgenerate

  always @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      wdata_r      <= 32'h0000_0000;
      cfg_r        <= 2'h0;
      dir_pol_r    <= 1'b0;
      last_pol_r   <= 1'b0;
      strap_done_r <= 1'b0;
    end else if (i_ce) begin
      if (!strap_done_r) begin
        // Straps sampled once after reset release
        dir_pol_r    <= i_boot_dir_pol;
        last_pol_r   <= i_boot_last_pol;
        strap_done_r <= 1'b1;
      end
      if (i_reg_wr && (i_reg_addr == `XBAP_OFF_WDATA)) begin
        wdata_r <= i_reg_wdata;
      end else if (i_reg_wr && (i_reg_addr == `XBAP_OFF_CFG)) begin
        cfg_r <= i_reg_wdata[1:0];
      end
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  always @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_reg_rdata <= 32'h0000_0000;
    end else if (i_ce) begin
      if (!i_reg_rd) begin
        o_reg_rdata <= 32'h0000_0000;
      end else if (i_reg_addr < `XBAP_OFF_CMD) begin
        o_reg_rdata <= {8'h00, ctl_r[i_reg_addr[1:0]]};
      end else if (i_reg_addr == `XBAP_OFF_CMD) begin
        o_reg_rdata <= {24'h00_0000, cmd_r};
      end else if (i_reg_addr == `XBAP_OFF_WDATA) begin
        o_reg_rdata <= wdata_r;
      end else if (i_reg_addr == `XBAP_OFF_STAT) begin
        o_reg_rdata <= {25'h000_0000, hq_in_ready, hq_out_valid, st_r, last_pol_r, busy_r};
      end else if (i_reg_addr == `XBAP_OFF_RDATA) begin
        o_reg_rdata <= rdata_r;
      end else if (i_reg_addr == `XBAP_OFF_HOSTDATA) begin
        o_reg_rdata <= hdata_r;
      end else if (i_reg_addr == `XBAP_OFF_CFG) begin
        o_reg_rdata <= {29'h0000_0000, dir_pol_r, cfg_r};
      end else begin
        o_reg_rdata <= 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------
  // Bus state machine
  // ----------------------------------------
  always @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      st_r        <= ST_IDLE;
      cnt_r       <= 4'h0;
      tail_r      <= 3'h0;
      rcnt_r      <= 3'h0;
      use_rdy_r   <= 1'b0;
      busy_r      <= 1'b0;
      cmd_r       <= 8'h00;
      rdata_r     <= 32'h0000_0000;
      hdata_r     <= 32'h0000_0000;
      hclk_d_r    <= 1'b0;
      host_rd_r   <= 1'b0;
      host_last_r <= 1'b0;
      rcap_r      <= 2'h0;
      o_space_chip_enable_n        <= 4'hF;
      o_byte_lane_pins             <= 4'h0;
      o_byte_lane_pins_oe          <= 1'b0;
      o_peripheral_output_enable_n <= 1'b1;
      o_read_strobe_n              <= 1'b1;
      o_write_strobe_n             <= 1'b1;
      o_write_strobe_oe            <= 1'b0;
      o_bus_ready_line             <= 1'b1;
      o_bus_ready_line_oe          <= 1'b0;
      o_bus_data_lines             <= 32'h0000_0000;
      o_bus_data_lines_oe          <= 1'b0;
    end else if (i_ce) begin
      hclk_d_r <= hclk_s;
      // Pin data lags two edges in the synchroniser; take it two edges after strobe rise
      rcap_r <= {rcap_r[0], 1'b0};
      if (rcap_r[1]) begin
        rdata_r <= dat_s;
      end
      // Enable may linger after the cycle; bounded by the tail count
      if (tail_r != 3'h0) begin
        tail_r <= tail_r - 3'h1;
        if (tail_r == 3'h1) begin
          o_space_chip_enable_n <= 4'hF;
        end
      end
      case (st_r)
        ST_IDLE: begin
          if (go) begin
            cmd_r  <= i_reg_wdata[7:0];
            busy_r <= 1'b1;
            st_r   <= ST_SETUP;
            cnt_r  <= 4'h0;
          end else if (hclk_rise && !hsel_n && !has_n) begin
            host_rd_r   <= ~host_dir_wr;
            host_last_r <= 1'b0;
            st_r        <= ST_HOST;
          end
        end
        ST_SETUP: begin
          // Selects driven from the first setup cycle
          o_space_chip_enable_n <= ~(4'h1 << cmd_r[1:0]);
          tail_r                <= 3'h0;
          o_byte_lane_pins      <= cmd_r[6:3];
          o_byte_lane_pins_oe   <= 1'b1;
          o_write_strobe_oe     <= 1'b1;
          o_peripheral_output_enable_n <= is_wr;
          o_bus_data_lines      <= wdata_r;
          o_bus_data_lines_oe   <= is_wr;
          use_rdy_r             <= cfg_r[0] && (sum_ss >= `XBAP_RDY_MIN_SUM);
          if ((cnt_r != 4'h0) && (cnt_r >= c_set)) begin
            cnt_r <= 4'h0;
            st_r  <= ST_STRB;
            o_read_strobe_n  <= is_wr;
            o_write_strobe_n <= ~is_wr;
          end else begin
            cnt_r <= cnt_r + 4'h1;
          end
        end
        ST_STRB: begin
          if (cnt_r + 4'h1 >= c_stb) begin
            if (use_rdy_r && !rdy_s) begin
              st_r <= ST_RDYW;
            end else begin
              o_read_strobe_n  <= 1'b1;
              o_write_strobe_n <= 1'b1;
              if (!is_wr) begin
                rcap_r[0] <= 1'b1;
              end
              cnt_r <= 4'h0;
              st_r  <= ST_HOLD;
            end
          end else begin
            cnt_r <= cnt_r + 4'h1;
          end
          rcnt_r <= 3'h0;
        end
        ST_RDYW: begin
          // Ready seen: three more cycles then strobe rises
          if (rdy_s || (rcnt_r != 3'h0)) begin
            if (rcnt_r == `XBAP_RDY_END_CYC - 1) begin
              o_read_strobe_n  <= 1'b1;
              o_write_strobe_n <= 1'b1;
              if (!is_wr) begin
                rcap_r[0] <= 1'b1;
              end
              cnt_r <= 4'h0;
              st_r  <= ST_HOLD;
            end else begin
              rcnt_r <= rcnt_r + 3'h1;
            end
          end
        end
        ST_HOLD: begin
          if (cnt_r >= c_hld) begin
            o_byte_lane_pins_oe          <= 1'b0;
            o_peripheral_output_enable_n <= 1'b1;
            o_bus_data_lines_oe          <= 1'b0;
            o_write_strobe_oe            <= 1'b0;
            tail_r <= `XBAP_CE_TAIL_CYC;
            busy_r <= 1'b0;
            st_r   <= ST_IDLE;
          end else begin
            cnt_r <= cnt_r + 4'h1;
          end
        end
        ST_HOST: begin
          o_bus_ready_line_oe <= 1'b1;
          // Active low ready; low when data is on hand or write can land
          o_bus_ready_line    <= host_rd_r ? ~hq_out_valid : 1'b0;
          if (hclk_rise) begin
            if (hsel_n || host_last_r) begin
              st_r   <= ST_REL;
              cnt_r  <= 4'h0;
              o_bus_data_lines_oe <= 1'b0;
            end else if (host_rd_r && hq_out_valid) begin
              o_bus_data_lines    <= hq_out_data;
              o_bus_data_lines_oe <= 1'b1;
              host_last_r         <= host_is_last;
            end else if (!host_rd_r) begin
              // Lane enables pick the bytes that land
              hdata_r[7:0]   <= hbe_n[0] ? hdata_r[7:0]   : dat_s[7:0];
              hdata_r[15:8]  <= hbe_n[1] ? hdata_r[15:8]  : dat_s[15:8];
              hdata_r[23:16] <= hbe_n[2] ? hdata_r[23:16] : dat_s[23:16];
              hdata_r[31:24] <= hbe_n[3] ? hdata_r[31:24] : dat_s[31:24];
              host_last_r    <= host_is_last | hctl;
            end
          end
        end
        ST_REL: begin
          o_bus_ready_line <= 1'b1;
          if (cnt_r + 4'h1 >= `XBAP_HZ_CYC) begin
            o_bus_ready_line_oe <= 1'b0;
            st_r <= ST_IDLE;
          end else begin
            cnt_r <= cnt_r + 4'h1;
          end
        end
        default: begin
          st_r <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // xbap_top

// ==== design/xbap_regs.vh ====
// Constants for the expansion bus peripheral master and host port slave.
// Assumes a 250 MHz core clock; included by the top design file only, not by the synchroniser or buffer files.
`ifndef XBAP_REGS_VH
`define XBAP_REGS_VH

// ----------------------------------------
// Register offsets (word addresses)
// ----------------------------------------
`define XBAP_ADDR_W        4
`define XBAP_OFF_CE0       4'h0
`define XBAP_OFF_CE1       4'h1
`define XBAP_OFF_CE2       4'h2
`define XBAP_OFF_CE3       4'h3
`define XBAP_OFF_CMD       4'h4
`define XBAP_OFF_WDATA     4'h5
`define XBAP_OFF_STAT      4'h6
`define XBAP_OFF_RDATA     4'h7
`define XBAP_OFF_HOSTDATA  4'h8
`define XBAP_OFF_CFG       4'h9

// ----------------------------------------
// Space control fields
// ----------------------------------------
`define XBAP_RS_LSB        0
`define XBAP_RST_LSB       4
`define XBAP_RH_LSB        8
`define XBAP_WS_LSB        12
`define XBAP_WST_LSB       16
`define XBAP_WH_LSB        20
`define XBAP_CNT_W         4
`define XBAP_CTL_RESET     24'h33_3333

// Command: [1:0] space, [2] write, [6:3] word address, [7] go
`define XBAP_CMD_WR_BIT    2
`define XBAP_CMD_GO_BIT    7

// ----------------------------------------
// Timing
// ----------------------------------------
`define XBAP_RDY_MIN_SUM   5'h04
`define XBAP_CE_TAIL_NS    28
`define XBAP_CLK_NS        4
// Tail of 28 ns at 4 ns per cycle, sized for the tail counter
`define XBAP_CE_TAIL_CYC   3'h7
`define XBAP_RDY_END_CYC   3
`define XBAP_HZ_CYC        2

`endif

// ==== design/xbap_sync2.v ====
// Two-flop synchroniser, vector wide.
// Assumes the input is asynchronous to i_ref_clk.
`timescale 1ns/1ps
module xbap_sync2 #(
  parameter W = 1
) (
  // Clock and reset
  input  wire         i_ref_clk,
  input  wire         i_rst_n,
  input  wire         i_ce,
  // Data
  input  wire [W-1:0] i_async,
  output reg  [W-1:0] o_sync
);
  reg [W-1:0] meta_r;

  always @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      meta_r <= {W{1'b0}};
      o_sync <= {W{1'b0}};
    end else if (i_ce) begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end
endmodule // xbap_sync2

// ==== design/xbap_buf2.v ====
// Two-entry valid/ready buffer.
// Assumes both sides run on i_ref_clk.
`timescale 1ns/1ps
module xbap_buf2 #(
  parameter W = 36
) (
  // Clock and reset
  input  wire         i_ref_clk,
  input  wire         i_rst_n,
  input  wire         i_ce,
  // Fill side
  input  wire         i_valid,
  output wire         o_ready,
  input  wire [W-1:0] i_data,
  // Drain side
  output wire         o_valid,
  input  wire         i_ready,
  output wire [W-1:0] o_data
);
  reg [W-1:0] mem_r [0:1];
  reg         wp_r;
  reg         rp_r;
  reg [1:0]   cnt_r;
  wire        push;
  wire        pop;

  assign o_ready = (cnt_r != 2'h2);
  assign o_valid = (cnt_r != 2'h0);
  assign o_data  = mem_r[rp_r];
  assign push    = i_valid & o_ready;
  assign pop     = o_valid & i_ready;

  always @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      wp_r  <= 1'b0;
      rp_r  <= 1'b0;
      cnt_r <= 2'h0;
    end else if (i_ce) begin
      if (push) begin
        wp_r <= ~wp_r;
      end
      if (pop) begin
        rp_r <= ~rp_r;
      end
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end

  always @(posedge i_ref_clk) begin
    if (i_ce && push) begin
      mem_r[wp_r] <= i_data;
    end
  end
endmodule // xbap_buf2

// ==== test/xbap_periph_model.sv ====
// Asynchronous peripheral model: 16-word store, ready raised after a set lag.
// Assumes strobes, selects and address pins come from the block under test.
`timescale 1ns/1ps
module xbap_periph_model (
  // Clock and control
  input  wire        i_clk,
  input  wire [31:0] i_lag,
  // Block pins
  input  wire [3:0]  i_addr,
  input  wire        i_oe_n,
  input  wire        i_re_n,
  input  wire        i_we_n,
  input  wire [31:0] i_wdata,
  // Answers
  output wire        o_ready,
  output wire [31:0] o_rdata
);
  logic [31:0] mem [16];
  logic [31:0] last = '0;
  logic [31:0] cnt = '0;

  initial begin
    for (int i = 0; i < 16; i++) mem[i] = 32'h5A00_0000 + i;
  end

  // Lag counts only while a strobe is low
  always @(posedge i_clk) begin
    cnt <= (i_re_n && i_we_n) ? '0 : cnt + 1;
    if (!i_oe_n) last <= mem[i_addr];
  end

  always @(posedge i_we_n) mem[i_addr] <= i_wdata;
  // Off-edge skew keeps ready truly asynchronous
  assign #1.3 o_ready = (cnt >= i_lag);
  // Released bus shows the inverse of the last word
  assign o_rdata = !i_oe_n ? mem[i_addr] : ~last;
endmodule // xbap_periph_model

// ==== test/xbap_top_sva.sv ====
// Checker for the expansion bus block, bound to its top module.
// Assumes the register port on i_ref_clk and ready extension in bit 0 of offset 0x9.
`timescale 1ns/1ps
module xbap_top_sva (
  // Clock and register port
  input wire        i_ref_clk,
  input wire        i_rst_n,
  input wire [3:0]  i_reg_addr,
  input wire [31:0] i_reg_wdata,
  input wire        i_reg_wr,
  // Pins
  input wire        i_bus_ready_line,
  input wire        i_host_port_select_n,
  input wire        i_host_bus_clock,
  input wire [3:0]  o_space_chip_enable_n,
  input wire        o_byte_lane_pins_oe,
  input wire        o_peripheral_output_enable_n,
  input wire        o_read_strobe_n,
  input wire        o_write_strobe_n,
  input wire        o_write_strobe_oe,
  input wire        o_bus_ready_line,
  input wire        o_bus_ready_line_oe,
  input wire        o_bus_data_lines_oe
);
  logic cfg_r;
  always @(posedge i_ref_clk) begin
    if (!i_rst_n) cfg_r <= 1'b0;
    else if (i_reg_wr && i_reg_addr == 4'h9) cfg_r <= i_reg_wdata[0];
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  rd_setup_a: assert property (
    $fell(o_read_strobe_n) |-> $past(o_byte_lane_pins_oe) && !$past(&o_space_chip_enable_n))
    else $error("read strobe fell without selects");
  wr_setup_a: assert property (
    $fell(o_write_strobe_n) |-> $past(o_byte_lane_pins_oe) && $past(o_bus_data_lines_oe))
    else $error("write strobe fell without selects");
  rd_hold_a: assert property (
    $rose(o_read_strobe_n) |-> o_byte_lane_pins_oe && !o_peripheral_output_enable_n)
    else $error("selects dropped with read strobe");
  wr_pin_a: assert property (
    !o_write_strobe_n |-> o_write_strobe_oe && o_bus_data_lines_oe)
    else $error("write strobe pin not driven");
  oe_read_a: assert property (
    !o_read_strobe_n |-> !o_peripheral_output_enable_n && !o_bus_data_lines_oe)
    else $error("read without output enable");
  ce_tail_a: assert property (
    $fell(o_byte_lane_pins_oe) |-> ##[0:8] (&o_space_chip_enable_n || o_byte_lane_pins_oe))
    else $error("chip enable lingers too long");
  rdy_ext_rd_a: assert property (
    cfg_r && $rose(i_bus_ready_line) && !o_read_strobe_n |-> (!o_read_strobe_n)[*3] ##[1:4] o_read_strobe_n)
    else $error("read strobe end off ready");
  rdy_ext_wr_a: assert property (
    cfg_r && $rose(i_bus_ready_line) && !o_write_strobe_n |-> (!o_write_strobe_n)[*3] ##[1:4] o_write_strobe_n)
    else $error("write strobe end off ready");
  rdy_input_a: assert property (
    !o_read_strobe_n || !o_write_strobe_n |-> !o_bus_ready_line_oe)
    else $error("ready driven in peripheral cycle");
  rdy_release_a: assert property (
    $fell(o_bus_ready_line_oe) |-> $past(o_bus_ready_line))
    else $error("ready released while low");
  data_release_a: assert property (
    $rose(i_host_bus_clock) && i_host_port_select_n |-> ##[1:4] !o_bus_data_lines_oe)
    else $error("data bus not released");

  cover property ($rose(o_read_strobe_n));
  cover property (cfg_r && $rose(i_bus_ready_line) && !o_write_strobe_n);
  cover property ($fell(o_bus_ready_line_oe));
endmodule // xbap_top_sva

bind xbap_top xbap_top_sva u_xbap_top_sva (.i_ref_clk, .i_rst_n, .i_reg_addr, .i_reg_wdata, .i_reg_wr,
  .i_bus_ready_line, .i_host_port_select_n, .i_host_bus_clock, .o_space_chip_enable_n, .o_byte_lane_pins_oe,
  .o_peripheral_output_enable_n, .o_read_strobe_n, .o_write_strobe_n, .o_write_strobe_oe,
  .o_bus_ready_line, .o_bus_ready_line_oe, .o_bus_data_lines_oe);

// ==== test/xbap_top_tb.sv ====
// Testbench: peripheral cycles, ready extension, host bursts under both straps.
// Assumes the peripheral model and the bound checker.
`timescale 1ns/1ps
module xbap_top_tb;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic        i_ref_clk = 1'b0, i_rst_n = 1'b0, i_ce = 1'b1, i_reg_wr = 1'b0, i_reg_rd = 1'b0;
  logic [3:0]  i_reg_addr = '0, i_byte_lane_enables_n = 4'hf, o_space_chip_enable_n, o_byte_lane_pins;
  logic [31:0] i_reg_wdata = '0, o_reg_rdata, o_bus_data_lines, hd = '0, m_d;
  logic        i_boot_dir_pol = 1'b0, i_boot_last_pol = 1'b0, i_host_bus_clock = 1'b0;
  logic        i_host_port_select_n = 1'b1, i_host_address_strobe_n = 1'b1, i_host_control_select = 1'b0;
  logic        i_transfer_direction = 1'b0, i_burst_last_flag = 1'b0, hd_en = 1'b0, m_rdy;
  logic        o_byte_lane_pins_oe, o_peripheral_output_enable_n, o_read_strobe_n, o_write_strobe_n;
  logic        o_write_strobe_oe, o_bus_ready_line, o_bus_ready_line_oe, o_bus_data_lines_oe;
  wire         i_bus_ready_line = o_bus_ready_line_oe ? o_bus_ready_line : m_rdy;
  wire  [31:0] i_bus_data_lines = o_bus_data_lines_oe ? o_bus_data_lines : hd_en ? hd : m_d;
  int          err_count = 0, num_checks = 0, lag = 0, su, wd, ho;
  int          cs [4], ct [4], ch [4];
  logic [31:0] mem [16];

  always #2 i_ref_clk = ~i_ref_clk;

  xbap_top u_xbap_top (.i_ref_clk, .i_rst_n, .i_ce, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd,
    .o_reg_rdata, .i_boot_dir_pol, .i_boot_last_pol, .o_space_chip_enable_n, .o_byte_lane_pins,
    .o_byte_lane_pins_oe, .o_peripheral_output_enable_n, .o_read_strobe_n, .o_write_strobe_n,
    .o_write_strobe_oe, .i_bus_ready_line, .o_bus_ready_line, .o_bus_ready_line_oe, .i_bus_data_lines,
    .o_bus_data_lines, .o_bus_data_lines_oe, .i_host_bus_clock, .i_host_port_select_n,
    .i_host_address_strobe_n, .i_host_control_select, .i_transfer_direction, .i_burst_last_flag,
    .i_byte_lane_enables_n);

  xbap_periph_model u_xbap_periph_model (.i_clk(i_ref_clk), .i_lag(lag), .i_addr(o_byte_lane_pins),
    .i_oe_n(o_peripheral_output_enable_n), .i_re_n(o_read_strobe_n), .i_we_n(o_write_strobe_n),
    .i_wdata(o_bus_data_lines), .o_ready(m_rdy), .o_rdata(m_d));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task tally_and_finish();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task chk(input logic [31:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task to();
    err_count++;
    $display("[ERR] %0t wait ran out", $time);
    tally_and_finish();
  endtask

  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    i_reg_addr <= a;
    i_reg_wdata <= d;
    i_reg_wr <= 1'b1;
    @(posedge i_ref_clk);
    i_reg_wr <= 1'b0;
  endtask

  task rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge i_ref_clk);
    i_reg_addr <= a;
    i_reg_rd <= 1'b1;
    @(posedge i_ref_clk);
    i_reg_rd <= 1'b0;
    #1 d = o_reg_rdata;
  endtask

  // Busy is polled; a hung cycle ends the run
  task op(input int sp, input logic w, input logic [3:0] a);
    int n;
    logic s;
    logic [31:0] st;
    su = 0;
    wd = 0;
    ho = 0;
    wr(4'h4, {24'h0, 1'b1, a, w, sp[1:0]});
    for (n = 0; n < 300 && (wd == 0 || o_byte_lane_pins_oe); n++) begin
      @(posedge i_ref_clk);
      #1 s = w ? o_write_strobe_n : o_read_strobe_n;
      if (!s) wd++;
      else if (wd == 0 && o_byte_lane_pins_oe) su++;
      else if (wd != 0 && o_byte_lane_pins_oe) ho++;
      if (!s && wd == 1) begin
        chk(o_space_chip_enable_n ^ (4'h1 << sp), 4'hf);
        chk(o_byte_lane_pins, a);
      end
    end
    if (n == 300) to();
    for (n = 0; n < 40; n++) begin
      rd(4'h6, st);
      if (st[0] === 1'b0) break;
    end
    if (n == 40) to();
  endtask

  task pchk(input int a);
    chk(su, cs[a] ? cs[a] : 1);
    chk(wd, ct[a] ? ct[a] : 1);
    chk(ho, ch[a] + 1);
  endtask

  // Host pins settle half a host period before each rising edge
  task hb(input logic s, as, l, input logic [3:0] be, input logic [31:0] d);
    i_host_port_select_n = s;
    i_host_address_strobe_n = as;
    i_burst_last_flag = l;
    i_byte_lane_enables_n = be;
    hd = d;
    #32 i_host_bus_clock = 1'b1;
    #32 i_host_bus_clock = 1'b0;
  endtask

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    logic [31:0] d, e, m;
    logic [3:0]  ad;
    int          a;
    void'($urandom(43));
    for (int i = 0; i < 16; i++) mem[i] = 32'h5A00_0000 + i;
    for (int p = 0; p < 2; p++) begin
      @(posedge i_ref_clk);
      i_rst_n <= 1'b0;
      i_boot_dir_pol <= p[0];
      i_boot_last_pol <= p[0];
      repeat (3) @(posedge i_ref_clk);
      i_rst_n <= 1'b1;
      if (p == 0) begin
        for (a = 0; a < 16; a++) begin
          if (a > 9) wr(a[3:0], $urandom);
          rd(a[3:0], d);
          if (a < 4 || a > 9) chk(d, a < 4 ? 32'h0033_3333 : 32'h0000_0000);
        end
        for (a = 0; a < 4; a++) begin
          cs[a] = $urandom % 16;
          ct[a] = $urandom % 16;
          ch[a] = $urandom % 16;
          wr(a[3:0], {8'h00, ch[a][3:0], ct[a][3:0], cs[a][3:0], ch[a][3:0], ct[a][3:0], cs[a][3:0]});
        end
        for (a = 0; a < 4; a++) begin
          ad = 4'($urandom);
          d = $urandom;
          mem[ad] = d;
          wr(4'h5, d);
          op(a, 1'b1, ad);
          pchk(a);
          op(a, 1'b0, ad);
          pchk(a);
          rd(4'h7, e);
          chk(e, mem[ad]);
        end
        wr(4'h9, 32'h0000_0001);
        wr(4'h0, 32'h0012_2122);
        wr(4'h1, 32'h0012_1121);
        lag = 10;
        op(0, 1'b1, 4'h3);
        chk(wd >= 12 && wd <= 18, 1);
        op(0, 1'b0, 4'h3);
        chk(wd >= 12 && wd <= 18, 1);
        lag = 20;
        op(1, 1'b0, 4'h6);
        chk(wd, 2);
      end
      d = $urandom;
      e = $urandom;
      @(posedge i_ref_clk);
      #1.7 hd_en = 1'b1;
      i_transfer_direction = ~p[0];
      hb(1'b0, 1'b0, p[0], 4'hf, '0);
      hb(1'b0, 1'b1, p[0], 4'h0, d);
      hb(1'b0, 1'b1, ~p[0], 4'ha, e);
      hb(1'b1, 1'b1, p[0], 4'hf, '0);
      hd_en = 1'b0;
      rd(4'h8, m);
      chk(m, (e & 32'h00ff_00ff) | (d & 32'hff00_ff00));
      wr(4'h8, d);
      wr(4'h8, e);
      rd(4'h6, m);
      chk(m[6:5], 2'b01);
      @(posedge i_ref_clk);
      #1.7 i_transfer_direction = p[0];
      hb(1'b0, 1'b0, p[0], 4'h0, '0);
      chk(o_bus_ready_line_oe, 1'b1);
      chk(o_bus_ready_line, 1'b0);
      hb(1'b0, 1'b1, ~p[0], 4'h0, '0);
      chk(o_bus_data_lines, d);
      chk(o_bus_data_lines_oe, 1'b1);
      hb(1'b1, 1'b1, p[0], 4'hf, '0);
      hb(1'b1, 1'b1, p[0], 4'hf, '0);
      chk(o_bus_data_lines_oe, 1'b0);
      chk(o_bus_ready_line_oe, 1'b0);
    end
    tally_and_finish();
  end
endmodule // xbap_top_tb
